// >>> pwm_timer_unit.sv
// Top of the PWM timer unit: run control, match shadows, PWM outputs
// and sticky event flags.
// Assumes configuration ports are driven by logic on clock_i; capture
// pins may be asynchronous and are synchronised inside.

`default_nettype none

module pwm_timer_unit
   import pwm_timer_pkg::*;
(
   // Clock and reset
   input  wire logic                             clock_i,
   input  wire logic                             rst_n_i,

   // Run control
   input  wire logic                             timer_en_i,
   input  wire logic                             counter_clear_i,
   input  wire logic                             pwm_mode_i,
   input  wire logic [CNT_W-1:0]                 prescale_i,

   // Match values and actions
   input  wire logic [NUM_MATCH-1:0][CNT_W-1:0]  match_value_i,
   input  wire logic [NUM_MATCH-1:0]             match_load_i,
   input  wire logic [NUM_MATCH-1:0]             match_release_i,
   input  wire logic [NUM_MATCH-1:0]             match_int_en_i,
   input  wire logic [NUM_MATCH-1:0]             match_reset_en_i,
   input  wire logic [NUM_MATCH-1:0]             match_stop_en_i,

   // PWM output configuration, bit 0 unused
   input  wire logic [NUM_PWM:0]                 out_en_i,
   input  wire logic [NUM_PWM:0]                 double_edge_i,

   // Capture pins and configuration
   input  wire logic [NUM_CAP-1:0]               capture_pin_i,
   input  wire logic [NUM_CAP-1:0]               capture_rise_i,
   input  wire logic [NUM_CAP-1:0]               capture_fall_i,
   input  wire logic [NUM_CAP-1:0]               capture_int_en_i,

   // Flag clear
   input  wire logic [NUM_FLAGS-1:0]             flag_clear_i,

   // Outputs
   output logic      [NUM_PWM:1]                 pwm_o,
   output logic      [CNT_W-1:0]                 count_o,
   output logic      [NUM_MATCH-1:0][CNT_W-1:0]  match_active_o,
   output logic      [NUM_MATCH-1:0]             release_pending_o,
   output logic      [NUM_CAP-1:0][CNT_W-1:0]    capture_value_o,
   output logic      [NUM_FLAGS-1:0]             flags_o,
   output logic                                  halted_o
);

   timer_link_if link ();

   run_state_e                        state_r;
   run_state_e                        state_nxt;
   logic [NUM_MATCH-1:0][CNT_W-1:0]   active_r;
   logic [NUM_MATCH-1:0][CNT_W-1:0]   pending_r;
   logic [NUM_MATCH-1:0]              release_r;
   logic [NUM_PWM:1]                  pwm_r;
   logic [NUM_FLAGS-1:0]              flags_r;
   logic                              halted_r;
   logic [NUM_MATCH-1:0]              hit;
   logic [NUM_CAP-1:0]                cap_event;
   logic                              cycle_start;
   logic                              stop_hit;

   // Counter core and capture channels

   timer_core u_core
   (
      .clock_i    (clock_i),
      .rst_n_i    (rst_n_i),
      .prescale_i (prescale_i),
      .link       (link.core)
   );

   capture_unit #(.N(NUM_CAP)) u_capture
   (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_i),
      .pin_i     (capture_pin_i),
      .rise_en_i (capture_rise_i),
      .fall_en_i (capture_fall_i),
      .event_o   (cap_event),
      .value_o   (capture_value_o),
      .link      (link.snoop)
   );

   // Match compare

   genvar m;
   for (m = 0; m < NUM_MATCH; m++)
   begin : g_hit
      // Compared only on a counter tick, so one event per count
      assign hit[m] = link.tick && (link.count == active_r[m]);
   end

   // In PWM mode the cycle match always restarts the count
   assign link.match_reset = (|(hit & match_reset_en_i)) ||
                             (pwm_mode_i && hit[CYCLE_IDX]);
   assign stop_hit    = |(hit & match_stop_en_i);
   assign cycle_start = pwm_mode_i && hit[CYCLE_IDX];
   assign link.run    = (state_r == ST_RUN);
   assign link.clear  = counter_clear_i;

   // Run state

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (timer_en_i)
               state_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            if (!timer_en_i)
               state_nxt = ST_IDLE;
            else if (stop_hit)
               state_nxt = ST_HALT;
         end
         ST_HALT:
         begin
            // Halt holds until software drops the enable
            if (!timer_en_i)
               state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
         halted_r <= 1'b0;
      else
         halted_r <= (state_nxt == ST_HALT);
   end

   // Match shadows: load, release, apply

   for (m = 0; m < NUM_MATCH; m++)
   begin : g_shadow
      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i)
            pending_r[m] <= MATCH_RESET;
         else if (match_load_i[m])
            pending_r[m] <= match_value_i[m];
      end

      // Release set wins over the clear at the apply point
      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i || !pwm_mode_i)
            release_r[m] <= 1'b0;
         else if (match_release_i[m])
            release_r[m] <= 1'b1;
         else if (cycle_start)
            release_r[m] <= 1'b0;
      end

      // Timer mode loads at once; PWM mode waits for release and
      // the cycle boundary so no pulse is cut short
      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i)
            active_r[m] <= MATCH_RESET;
         else if (!pwm_mode_i && match_load_i[m])
            active_r[m] <= match_value_i[m];
         else if (cycle_start && release_r[m])
            active_r[m] <= pending_r[m];
      end
   end

   // PWM outputs

   genvar p;
   for (p = 1; p <= NUM_PWM; p++)
   begin : g_pwm
      logic             set_edge;
      logic             clr_edge;
      logic [CNT_W-1:0] start_val;

      // Value in force for the cycle that opens at the next cycle match;
      // testing the old value would leave a glitch or a lost pulse
      assign start_val = release_r[p] ? pending_r[p] : active_r[p];

      if (p >= 2)
      begin : g_dbl
         // Double edge pairs match p-1 (rise) with match p (fall)
         always_comb
         begin
            if (double_edge_i[p])
            begin
               set_edge = hit[p-1];
               clr_edge = hit[p];
            end
            else
            begin
               set_edge = hit[CYCLE_IDX] &&
                          (start_val != CONST_LOW);
               clr_edge = hit[p] ||
                          (hit[CYCLE_IDX] &&
                           (start_val == CONST_LOW));
            end
         end
      end
      else
      begin : g_sgl
         // Output 1 would pair with the cycle match below it, so it is single edge only
         always_comb
         begin
            set_edge = hit[CYCLE_IDX] &&
                       (start_val != CONST_LOW);
            clr_edge = hit[p] ||
                       (hit[CYCLE_IDX] &&
                        (start_val == CONST_LOW));
         end
      end

      // Clear wins a tie, so equal edges give a steady low
      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i || !pwm_mode_i || !out_en_i[p])
            pwm_r[p] <= 1'b0;
         else if (clr_edge)
            pwm_r[p] <= 1'b0;
         else if (set_edge)
            pwm_r[p] <= 1'b1;
      end
   end

   // Sticky flags: a new event beats a clear in the same cycle

   for (m = 0; m < NUM_MATCH; m++)
   begin : g_mflag
      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i)
            flags_r[m] <= 1'b0;
         else if (hit[m] && match_int_en_i[m])
            flags_r[m] <= 1'b1;
         else if (flag_clear_i[m])
            flags_r[m] <= 1'b0;
      end
   end

   genvar c;
   for (c = 0; c < NUM_CAP; c++)
   begin : g_cflag
      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i)
            flags_r[CAP_FLAG_BASE+c] <= 1'b0;
         else if (cap_event[c] && capture_int_en_i[c])
            flags_r[CAP_FLAG_BASE+c] <= 1'b1;
         else if (flag_clear_i[CAP_FLAG_BASE+c])
            flags_r[CAP_FLAG_BASE+c] <= 1'b0;
      end
   end

   // Outputs

   assign pwm_o             = pwm_r;
   assign count_o           = link.count;
   assign match_active_o    = active_r;
   assign release_pending_o = release_r;
   assign flags_o           = flags_r;
   assign halted_o          = halted_r;

endmodule : pwm_timer_unit

`default_nettype wire

// >>> pwm_timer_pkg.sv
// Constants and types shared by the PWM timer unit.
// Assumes a single clock domain and a synchronous, active-low reset.
//
// Functional notes
// - Clock cycles are counted in a 32-bit counter behind a 32-bit prescaler that sets cycles per count.
// - Seven match registers are compared with the counter and each match can raise a flag.
// - Each match can keep counting, stop the counter or reset it, each with its own flag enable.
// - Four capture inputs store the counter on a chosen edge and can raise a flag.
// - In PWM mode a count equal to the cycle match register resets the counter, giving the common period.
// - A single-edge output rises at the cycle match and falls at its own match value.
// - A single-edge output programmed for constant low stays low for the whole cycle.
// - A double-edge output rises on one match register and falls on the next one.
// - Either double edge may sit at any counter position in the cycle.
// - Up to six single-edge, five double-edge (outputs 2 to 6), or a mix of outputs fit the seven matches.
// - All outputs share one period and period and width take any whole count.
// - In PWM mode new match values take effect only at the start of a PWM cycle.
// - With PWM mode off the unit is a plain timer and the outputs stay low.

`default_nettype none

package pwm_timer_pkg;

   localparam int unsigned CNT_W         = 32;
   localparam int unsigned NUM_MATCH     = 7;
   localparam int unsigned NUM_CAP       = 4;
   localparam int unsigned NUM_PWM       = 6;
   localparam int unsigned CYCLE_IDX     = 0;
   localparam int unsigned CAP_FLAG_BASE = NUM_MATCH;
   localparam int unsigned NUM_FLAGS     = NUM_MATCH + NUM_CAP;

   localparam logic [CNT_W-1:0] CNT_RESET   = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE     = 32'h0000_0001;
   localparam logic [CNT_W-1:0] MATCH_RESET = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CONST_LOW   = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_RUN  = 3'b010,
      ST_HALT = 3'b100
   } run_state_e;

endpackage : pwm_timer_pkg

`default_nettype wire

// >>> timer_link_if.sv
// Carrier between the counter core, the capture block and the top.
// Assumes all parties sit on the same clock.

`default_nettype none

interface timer_link_if
   import pwm_timer_pkg::*;
   ();
   logic [CNT_W-1:0] count;
   logic             tick;
   logic             run;
   logic             clear;
   logic             match_reset;

   modport core (input run, input clear, input match_reset,
                 output count, output tick);
   modport user (output run, output clear, output match_reset,
                 input count, input tick);
   modport snoop (input count);
endinterface : timer_link_if

`default_nettype wire

// >>> timer_core.sv
// Prescaler and 32-bit count register.
// Assumes run, clear and match_reset come from logic on the same clock.

`default_nettype none

module timer_core
   import pwm_timer_pkg::*;
(
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // Configuration
   input  wire logic [CNT_W-1:0] prescale_i,
   // Link to the top
   timer_link_if.core            link
);

   logic [CNT_W-1:0] pre_r;
   logic [CNT_W-1:0] count_r;

   // Tick ends each run of prescale_i + 1 clock cycles
   assign link.tick  = link.run && (pre_r == prescale_i);
   assign link.count = count_r;

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || link.clear || !link.run)
         pre_r <= CNT_RESET;
      else if (pre_r == prescale_i)
         pre_r <= CNT_RESET;
      else
         pre_r <= pre_r + CNT_ONE;
   end

   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i || link.clear)
         count_r <= CNT_RESET;
      else if (link.tick && link.match_reset)
         count_r <= CNT_RESET;
      else if (link.tick)
         count_r <= count_r + CNT_ONE;
   end

endmodule : timer_core

`default_nettype wire

// >>> capture_unit.sv
// Capture channels: pin synchroniser, edge select and value store.
// Assumes capture pins are asynchronous to the clock.

`default_nettype none

module capture_unit
   import pwm_timer_pkg::*;
#(
   parameter int unsigned N = NUM_CAP
)
(
   // Clock and reset
   input  wire logic                     clock_i,
   input  wire logic                     rst_n_i,
   // Pins and edge selection
   input  wire logic [N-1:0]             pin_i,
   input  wire logic [N-1:0]             rise_en_i,
   input  wire logic [N-1:0]             fall_en_i,
   // Results
   output logic      [N-1:0]             event_o,
   output logic      [N-1:0][CNT_W-1:0]  value_o,
   // Counter snoop
   timer_link_if.snoop                   link
);

   logic [N-1:0] meta_r;
   logic [N-1:0] sync_r;
   logic [N-1:0] prev_r;

   // Only sync_r and prev_r feed the edge detect
   always_ff @(posedge clock_i)
   begin
      if (!rst_n_i)
      begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end
      else
      begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   genvar g;
   for (g = 0; g < N; g++)
   begin : g_cap
      assign event_o[g] = (rise_en_i[g] && sync_r[g] && !prev_r[g]) ||
                          (fall_en_i[g] && !sync_r[g] && prev_r[g]);

      always_ff @(posedge clock_i)
      begin
         if (!rst_n_i)
            value_o[g] <= CNT_RESET;
         else if (event_o[g])
            value_o[g] <= link.count;
      end
   end

endmodule : capture_unit

`default_nettype wire

// >>> pwm_timer_unit_assertions.sv
// Concurrent checks on the PWM timer unit top ports.
// Assumes one clock domain and the synchronous active-low reset.
`default_nettype none

module pwm_timer_unit_assertions
   import pwm_timer_pkg::*;
(
   input wire logic                            clock_i,
   input wire logic                            rst_n_i,
   input wire logic                            counter_clear_i,
   input wire logic                            pwm_mode_i,
   input wire logic [NUM_PWM:0]                out_en_i,
   input wire logic [NUM_FLAGS-1:0]            flag_clear_i,
   input wire logic [NUM_PWM:1]                pwm_o,
   input wire logic [CNT_W-1:0]                count_o,
   input wire logic [NUM_MATCH-1:0][CNT_W-1:0] match_active_o,
   input wire logic [NUM_MATCH-1:0]            release_pending_o,
   input wire logic [NUM_FLAGS-1:0]            flags_o,
   input wire logic                            halted_o
);
   logic [CNT_W-1:0] mr0;
   logic [CNT_W-1:0] mr1;
   logic             on1;

   assign mr0 = match_active_o[0];
   assign mr1 = match_active_o[1];
   assign on1 = pwm_mode_i & out_en_i[1];

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_PWM_OFF:
      assert property (!pwm_mode_i |=> pwm_o == '0)
      else $error("pwm high in timer mode");
   AST_STICKY:
      assert property (1'b1 |=>
         ($past(flags_o) & ~$past(flag_clear_i) & ~flags_o) == '0)
      else $error("flag dropped without clear");
   AST_STEP:
      assert property ($changed(count_o) && !$past(counter_clear_i) |->
         count_o == $past(count_o) + CNT_ONE || count_o == CNT_RESET)
      else $error("count moved by other than one");
   AST_WRAP:
      assert property ($past(pwm_mode_i) && $changed(count_o) &&
         $past(count_o) == $past(mr0) |-> count_o == CNT_RESET)
      else $error("no wrap at cycle match");
   AST_APPLY_SYNC:
      assert property ($past(pwm_mode_i) && $changed(match_active_o) |->
         $past(count_o) == $past(mr0))
      else $error("match applied off cycle start");
   AST_RELEASED:
      assert property ($past(pwm_mode_i) && $changed(match_active_o) |->
         $past(release_pending_o) != '0)
      else $error("match applied without release");
   AST_RISE:
      assert property ($rose(pwm_o[1]) && $past(on1) && $past(on1, 2) |->
         $past(count_o) == $past(mr0))
      else $error("single edge rise off cycle match");
   AST_FALL:
      assert property ($fell(pwm_o[1]) && $past(on1) |->
         $past(count_o) == $past(mr1) ||
         (mr1 == CONST_LOW && $past(release_pending_o[1])))
      else $error("single edge fall off own match");
   AST_CONST_LOW:
      assert property (pwm_mode_i && mr1 == CONST_LOW && $stable(mr1) &&
         !release_pending_o[1] |=> !pwm_o[1])
      else $error("constant low output went high");
   AST_HALT:
      assert property (halted_o && !counter_clear_i |=> $stable(count_o))
      else $error("count moved while halted");

endmodule : pwm_timer_unit_assertions

bind pwm_timer_unit pwm_timer_unit_assertions u_chk (
   .clock_i, .rst_n_i, .counter_clear_i, .pwm_mode_i, .out_en_i,
   .flag_clear_i, .pwm_o, .count_o, .match_active_o, .release_pending_o,
   .flags_o, .halted_o
);

`default_nettype wire

// >>> pwm_load_model.sv
// Load model: integrates how long each PWM line is driven high.
// Assumes the bench holds gate_i high over whole PWM periods.
`default_nettype none

module pwm_load_model
   import pwm_timer_pkg::*;
(
   input  wire logic                   clock_i,
   input  wire logic                   gate_i,
   input  wire logic [NUM_PWM:1]       drive_i,
   output logic      [NUM_PWM:1][31:0] on_time_o
);
   // Gate low empties the integrators between measurements
   always_ff @(posedge clock_i)
      for (int k = 1; k <= NUM_PWM; k++)
         if (!gate_i)
            on_time_o[k] <= '0;
         else if (drive_i[k])
            on_time_o[k] <= on_time_o[k] + 32'h1;

endmodule : pwm_load_model

`default_nettype wire

// >>> test_pwm_timer_unit.sv
// Self-checking bench for the PWM timer unit with a load model.
// Assumes the package constants and registered port timing.
`default_nettype none

module test_pwm_timer_unit
   import pwm_timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                            clock_i = 1'b0;
   logic                            rst_n_i, timer_en_i, counter_clear_i;
   logic                            pwm_mode_i, gate, halted_o;
   logic [CNT_W-1:0]                prescale_i, count_o, v, w, p;
   logic [NUM_MATCH-1:0][CNT_W-1:0] match_value_i, match_active_o;
   logic [NUM_MATCH-1:0]            match_load_i, match_release_i;
   logic [NUM_MATCH-1:0]            match_int_en_i, match_reset_en_i;
   logic [NUM_MATCH-1:0]            match_stop_en_i, release_pending_o;
   logic [NUM_PWM:0]                out_en_i, double_edge_i;
   logic [NUM_CAP-1:0]              capture_pin_i, capture_rise_i;
   logic [NUM_CAP-1:0]              capture_fall_i, capture_int_en_i;
   logic [NUM_CAP-1:0][CNT_W-1:0]   capture_value_o;
   logic [NUM_FLAGS-1:0]            flag_clear_i, flags_o;
   logic [NUM_PWM:1]                pwm_o;
   logic [NUM_PWM:1][31:0]          on_time;
   int                              checked = 0;
   int                              mismatches = 0;

   pwm_timer_unit u_dut (
      .clock_i, .rst_n_i, .timer_en_i, .counter_clear_i, .pwm_mode_i,
      .prescale_i, .match_value_i, .match_load_i, .match_release_i,
      .match_int_en_i, .match_reset_en_i, .match_stop_en_i, .out_en_i,
      .double_edge_i, .capture_pin_i, .capture_rise_i, .capture_fall_i,
      .capture_int_en_i, .flag_clear_i, .pwm_o, .count_o,
      .match_active_o, .release_pending_o, .capture_value_o, .flags_o,
      .halted_o
   );

   pwm_load_model u_load (
      .clock_i, .gate_i(gate), .drive_i(pwm_o), .on_time_o(on_time)
   );

   always #20 clock_i = ~clock_i;

   task automatic tick(input int n);
      repeat (n) @(negedge clock_i);
   endtask : tick

   task automatic chk(input string what, input logic [31:0] e, g);
      checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", what, e, g);
         mismatches++;
      end
   endtask : chk

   task automatic pulse(ref logic [NUM_MATCH-1:0] s);
      s = '1;
      tick(1);
      s = '0;
   endtask : pulse

   // High counts per period; tie of double edges gives no pulse
   function automatic logic [31:0] hi_exp(input int n);
      logic [31:0] r;
      logic [31:0] f;
      r = match_value_i[n-1];
      f = match_value_i[n];
      if (!double_edge_i[n])
         return (f == 0) ? 0 : f + 1;
      if (f >= r)
         return f - r;
      return match_value_i[0] + 1 - (r - f);
   endfunction : hi_exp

   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : print_verdict

   initial
   begin
      {rst_n_i, timer_en_i, counter_clear_i, pwm_mode_i, gate, prescale_i,
       match_value_i, match_load_i, match_release_i, match_int_en_i,
       match_reset_en_i, match_stop_en_i, out_en_i, double_edge_i,
       capture_pin_i, capture_rise_i, capture_fall_i, capture_int_en_i,
       flag_clear_i} = '0;
      void'($urandom(32'hddf4ee2d));
      tick(5);
      rst_n_i = 1'b1;
      chk("reset count", 0, count_o);
      chk("reset flags", 0, flags_o);
      pwm_mode_i = 1'b1;
      timer_en_i = 1'b1;
      match_int_en_i = '1;
      for (int it = 0; it < 6; it++)
      begin
         p = (it == 0) ? 0 : $urandom % 3;
         match_value_i[0] = 4 + $urandom % 12;
         for (int i = 1; i < NUM_MATCH; i++)
            match_value_i[i] = 1 + $urandom % (match_value_i[0] - 1);
         double_edge_i = (it == 0) ? '0 :
                         (it == 1) ? 7'h7c : {5'($urandom), 2'b00};
         out_en_i = (it < 2) ? '1 : 7'($urandom);
         if (it == 0)
            match_value_i[3] = '0;
         if (it == 1)
            match_value_i[5] = match_value_i[4];
         // Output 1 held low for a whole cycle after a release
         if (it == 2)
            match_value_i[1] = '0;
         // Prescale only changes under clear, so no tick is skipped
         prescale_i = p;
         counter_clear_i = 1'b1;
         pulse(match_load_i);
         counter_clear_i = 1'b0;
         pulse(match_release_i);
         chk("pending", 7'h7f, release_pending_o);
         for (int n = 0; n < 300 && release_pending_o !== '0; n++)
            tick(1);
         for (int i = 0; i < NUM_MATCH; i++)
            chk("applied", match_value_i[i], match_active_o[i]);
         w = (match_value_i[0] + 1) * (p + 1);
         tick(2 * w);
         gate = 1'b1;
         tick(2 * w);
         for (int n = 1; n <= NUM_PWM; n++)
            chk("high time", out_en_i[n] ? 2 * (p + 1) * hi_exp(n) : 0,
                on_time[n]);
         gate = 1'b0;
      end
      v = match_value_i[2];
      match_value_i[2] = v ^ 32'h1;
      pulse(match_load_i);
      tick(3 * w);
      chk("unreleased", v, match_active_o[2]);
      pulse(match_release_i);
      tick(2 * w);
      chk("released", v ^ 32'h1, match_active_o[2]);
      $display("test pwm finished");
      {pwm_mode_i, timer_en_i, prescale_i} = '0;
      {counter_clear_i, flag_clear_i} = '1;
      for (int i = 0; i < NUM_MATCH; i++)
         match_value_i[i] = i + 3;
      match_reset_en_i = 7'h40;
      tick(2);
      pulse(match_load_i);
      {counter_clear_i, flag_clear_i, timer_en_i} = 13'h1;
      tick(30);
      chk("timer pwm", 0, pwm_o);
      chk("wrap", 1, count_o <= 9);
      chk("all matches", 7'h7f, flags_o[6:0]);
      match_int_en_i = 7'($urandom);
      flag_clear_i = '1;
      tick(2);
      flag_clear_i = '0;
      tick(12);
      chk("enabled flags", match_int_en_i, flags_o[6:0]);
      match_stop_en_i = 7'h10;
      tick(12);
      chk("halted", 1, halted_o);
      chk("stop count", 8, count_o);
      capture_rise_i = '1;
      capture_int_en_i = 4'($urandom);
      for (int i = 0; i < NUM_CAP; i++)
      begin
         capture_pin_i[i] = 1'b1;
         tick(5);
         chk("rise value", 8, capture_value_o[i]);
         chk("cap flag", capture_int_en_i[i],
             flags_o[CAP_FLAG_BASE + i]);
      end
      counter_clear_i = 1'b1;
      {capture_rise_i, capture_fall_i, capture_pin_i} = 12'h0f0;
      tick(5);
      for (int i = 0; i < NUM_CAP; i++)
         chk("fall value", 0, capture_value_o[i]);
      $display("test timer finished");
      print_verdict();
   end

   // Roughly ten times the longest expected run
   initial
   begin
      repeat (20000) @(posedge clock_i);
      mismatches++;
      print_verdict();
   end

endmodule : test_pwm_timer_unit

`default_nettype wire
